// ---- hw/fss_pkg.sv ----
package fss_pkg;

  // --------------------------------------------------------------
  // command destinations (top nibble of the 16-bit command word; dwell takes the top two bits)
  // --------------------------------------------------------------
  localparam logic [3:0] CMD_CONTROL    = 4'h0;
  localparam logic [3:0] CMD_STEP_COUNT = 4'h1;
  localparam logic [3:0] CMD_FSTEP_LO   = 4'h2;
  localparam logic [3:0] CMD_FSTEP_HI   = 4'h3;
  localparam logic [1:0] CMD_DWELL_TOP  = 2'h1;
  localparam logic [3:0] CMD_START_LO   = 4'hC;
  localparam logic [3:0] CMD_START_HI   = 4'hD;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int CMD_CODE_LSB       = 12;
  localparam int CTL_FULL_WORD_BIT  = 11;
  localparam int CTL_DAC_EN_BIT     = 10;
  localparam int CTL_SHAPE_BIT      = 9;
  localparam int CTL_SQ_EN_BIT      = 8;
  localparam int CTL_SRC_BIT        = 5;
  localparam int CTL_MARK_MODE_BIT  = 3;
  localparam int CTL_MARK_EN_BIT    = 2;
  localparam int FSTEP_DIR_BIT      = 11;
  localparam int DWELL_UNIT_BIT     = 13;
  localparam int DWELL_MULT_LSB     = 11;

  // --------------------------------------------------------------
  // widths, reset values, timing
  // --------------------------------------------------------------
  localparam int FREQ_W   = 24;
  localparam int FSTEP_W  = 23;
  localparam int COUNT_W  = 12;
  localparam int DWELL_W  = 14;
  localparam int DAC_W    = 10;
  localparam logic [9:0] DAC_MIDSCALE = 10'h200;
  localparam logic       RST_DAC_EN   = 1'b1;
  localparam logic       RST_SHAPE    = 1'b1;
  localparam logic [2:0] MARK_PULSE_CYCLES = 3'h4;
  localparam logic [8:0] MULT_X1   = 9'h001;
  localparam logic [8:0] MULT_X5   = 9'h005;
  localparam logic [8:0] MULT_X100 = 9'h064;
  localparam logic [8:0] MULT_X500 = 9'h1F4;

  // quarter-wave sine, 32 points, amplitude 511
  localparam logic [8:0] SINE_Q [32] = '{
    9'h00D, 9'h026, 9'h03F, 9'h057, 9'h070, 9'h088, 9'h0A0, 9'h0B8,
    9'h0CF, 9'h0E6, 9'h0FC, 9'h111, 9'h126, 9'h13A, 9'h14E, 9'h160,
    9'h172, 9'h183, 9'h193, 9'h1A2, 9'h1B0, 9'h1BD, 9'h1C8, 9'h1D3,
    9'h1DD, 9'h1E5, 9'h1EC, 9'h1F3, 9'h1F7, 9'h1FB, 9'h1FE, 9'h1FF};

  typedef enum logic [1:0] {
    FSS_IDLE = 2'b00,
    FSS_RUN  = 2'b01,
    FSS_DONE = 2'b11
  } fss_state_t;

endpackage

// ---- hw/fss_top.sv ----
// How it works
// [RULE_01] each step adds signed increment to tuning word
// [RULE_02] start, start+step, ... up to start+N*step
// [RULE_03] 23-bit increment loaded by two commands
// [RULE_04] top nibble picks destination register
// [RULE_05] high increment write D11 sets direction
// [RULE_06] step count 12 bits from low bits
// [RULE_07] step count binary, host programs two or more
// [RULE_08] dwell D13 picks waveform cycles or clocks
// [RULE_09] dwell count 11 bits, host keeps 2..2047
// [RULE_10] D12:D11 multiply clock period 1/5/100/500
// [RULE_11] every frequency, start included, held one interval; with waveform-cycle dwell the start is held half a cycle short
// [RULE_12] trigger rising edge starts scan at start
// [RULE_13] internal source: advance after each dwell
// [RULE_14] external source: later trigger edges advance
// [RULE_15] abort rising edge resets, output to midscale
// [RULE_16] standby freezes accumulator, scan resumes after
// [RULE_17] host resets before and after standby
// [RULE_18] shape bit: sine lookup or triangle
// [RULE_19] host sets converter enable when output used
// [RULE_20] square pin shows inverted converter MSB
// [RULE_21] marker enable gates pin, mode picks behaviour
// [RULE_22] marker: end of scan or 4-clock step pulse
// [RULE_23] end marker clears at next start; disabled floats
// [RULE_24] start frequency two 12-bit halves, paired load
// [RULE_25] 16 bits per frame, MSB first, falling edge
// [RULE_26] last frequency held until reset
// [RULE_27] undefined destination codes are ignored
module fss_top
  import fss_pkg::*;
(
  input  wire logic             MCLK,
  input  wire logic             RST_N,
  input  wire logic             SCLK,
  input  wire logic             FRAME_SELECT_N,
  input  wire logic             SERIAL_DATA_IN,
  input  wire logic             SCAN_TRIGGER,
  input  wire logic             ABORT,
  input  wire logic             STANDBY,
  output logic [DAC_W-1:0]      ANALOG_OUT,
  output logic                  SQUARE_WAVE_OUT,
  output logic                  SCAN_MARKER_OUT,
  output logic                  SCAN_MARKER_OE
);

  // --------------------------------------------------------------
  // serial link domain: shifts on falling SCLK
  // --------------------------------------------------------------
  typedef struct packed {
    logic [14:0] shift;
    logic [3:0]  bit_cnt;
    logic [15:0] word;
    logic        toggle;
  } fss_link_t;

  fss_link_t lnk_reg;
  fss_link_t lnk_next;

  always_comb begin
    lnk_next = lnk_reg;
    if (FRAME_SELECT_N) begin
      lnk_next.bit_cnt = 4'h0;
    end else begin
      lnk_next.shift   = {lnk_reg.shift[13:0], SERIAL_DATA_IN};  // [RULE_25]
      lnk_next.bit_cnt = lnk_reg.bit_cnt + 4'h1;
      if (lnk_reg.bit_cnt == 4'hF) begin
        // word stays put until the next frame, long enough to cross
        lnk_next.word   = {lnk_reg.shift, SERIAL_DATA_IN};  // [RULE_25]
        lnk_next.toggle = ~lnk_reg.toggle;
      end
    end
  end

  always_ff @(negedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      lnk_reg <= '0;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  // --------------------------------------------------------------
  // master clock domain state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [2:0]         tog_s;
    logic [2:0]         trg_s;
    logic [2:0]         abt_s;
    logic [1:0]         stb_s;
    logic               full_word;
    logic               dac_en;
    logic               shape_sine;
    logic               sq_en;
    logic               src_ext;
    logic               mark_mode;
    logic               mark_en;
    logic [FREQ_W-1:0]  start_freq;
    logic [11:0]        start_lo_pend;
    logic [FSTEP_W-1:0] fstep;
    logic               fstep_down;
    logic [COUNT_W-1:0] step_count;
    logic [DWELL_W-1:0] dwell;
    fss_state_t         state;
    logic [COUNT_W-1:0] idx;
    logic [FREQ_W-1:0]  freq;
    logic [FREQ_W-1:0]  phase;
    logic               phase_msb_d;
    logic [10:0]        dwell_cnt;
    logic [8:0]         pre_cnt;
    logic [2:0]         mark_cnt;
    logic               eos;
    logic [DAC_W-1:0]   dac;
    logic               square;
    logic               marker;
  } fss_core_t;

  fss_core_t r_reg;
  fss_core_t r_next;

  function automatic logic [8:0] mult_of(input logic [1:0] sel);
    case (sel)
      2'h0:    mult_of = MULT_X1;
      2'h1:    mult_of = MULT_X5;
      2'h2:    mult_of = MULT_X100;
      default: mult_of = MULT_X500;
    endcase
  endfunction

  function automatic logic [9:0] sine_of(input logic [FREQ_W-1:0] ph);
    logic [4:0] i;
    logic [8:0] a;
    i = ph[FREQ_W-3] ? ~ph[FREQ_W-4:FREQ_W-8] : ph[FREQ_W-4:FREQ_W-8];
    a = SINE_Q[i];
    sine_of = ph[FREQ_W-1] ? (DAC_MIDSCALE - 10'h001 - {1'b0, a})
                           : (DAC_MIDSCALE + {1'b0, a});
  endfunction

  logic               word_new;
  logic [15:0]        cmd;
  logic [3:0]         code;
  logic               trig_rise;
  logic               abort_rise;
  logic               standby;
  logic               reset_scan;
  logic               step_evt;
  logic               tick;
  logic [8:0]         mult;
  logic [FREQ_W-1:0]  fstep_ext;
  logic [DAC_W-1:0]   wave;

  always_comb begin
    r_next = r_reg;

    // ------------------------------------------------------------
    // synchronisers: first stage read only by the second
    // ------------------------------------------------------------
    r_next.tog_s = {r_reg.tog_s[1:0], lnk_reg.toggle};
    r_next.trg_s = {r_reg.trg_s[1:0], SCAN_TRIGGER};
    r_next.abt_s = {r_reg.abt_s[1:0], ABORT};
    r_next.stb_s = {r_reg.stb_s[0], STANDBY};

    word_new   = r_reg.tog_s[2] ^ r_reg.tog_s[1];
    cmd        = lnk_reg.word;
    code       = cmd[15:CMD_CODE_LSB];
    trig_rise  = r_reg.trg_s[1] & ~r_reg.trg_s[2];
    abort_rise = r_reg.abt_s[1] & ~r_reg.abt_s[2];
    standby    = r_reg.stb_s[1];
    reset_scan = abort_rise;
    mult       = mult_of(r_reg.dwell[DWELL_MULT_LSB +: 2]);
    fstep_ext  = {1'b0, r_reg.fstep};
    tick       = 1'b0;
    step_evt   = 1'b0;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    if (word_new) begin
      if (code == CMD_CONTROL) begin
        r_next.full_word  = cmd[CTL_FULL_WORD_BIT];
        r_next.dac_en     = cmd[CTL_DAC_EN_BIT];
        r_next.shape_sine = cmd[CTL_SHAPE_BIT];
        r_next.sq_en      = cmd[CTL_SQ_EN_BIT];
        r_next.src_ext    = cmd[CTL_SRC_BIT];
        r_next.mark_mode  = cmd[CTL_MARK_MODE_BIT];
        r_next.mark_en    = cmd[CTL_MARK_EN_BIT];
        // a control write doubles as the soft reset of the scan
        reset_scan        = 1'b1;
      end else if (code == CMD_STEP_COUNT) begin
        r_next.step_count = cmd[COUNT_W-1:0];  // [RULE_06] [RULE_07]
      end else if (code == CMD_FSTEP_LO) begin
        r_next.fstep[11:0] = cmd[11:0];  // [RULE_03] [RULE_04]
      end else if (code == CMD_FSTEP_HI) begin
        r_next.fstep[FSTEP_W-1:12] = cmd[10:0];  // [RULE_03] [RULE_04]
        r_next.fstep_down = cmd[FSTEP_DIR_BIT];  // [RULE_05]
      end else if (code[3:2] == CMD_DWELL_TOP) begin
        r_next.dwell = cmd[DWELL_W-1:0];  // [RULE_08] [RULE_09] [RULE_10]
      end else if (code == CMD_START_LO) begin
        if (r_reg.full_word) begin
          r_next.start_lo_pend = cmd[11:0];  // [RULE_24]
        end else begin
          r_next.start_freq[11:0] = cmd[11:0];  // [RULE_24]
        end
      end else if (code == CMD_START_HI) begin
        r_next.start_freq[FREQ_W-1:12] = cmd[11:0];  // [RULE_24]
        if (r_reg.full_word) begin
          r_next.start_freq[11:0] = r_reg.start_lo_pend;  // [RULE_24]
        end
      end
      // any other code falls through untouched  [RULE_27]
    end

    // ------------------------------------------------------------
    // scan sequencer; standby freezes all of it but the marker pulse countdown, instead of gating MCLK
    // ------------------------------------------------------------
    if (r_reg.mark_cnt != 3'h0) begin
      r_next.mark_cnt = r_reg.mark_cnt - 3'h1;
    end

    if (reset_scan) begin
      r_next.state    = FSS_IDLE;  // [RULE_15]
      r_next.phase    = '0;
      r_next.idx      = '0;
      r_next.eos      = 1'b0;
      r_next.mark_cnt = 3'h0;
    end else if (!standby) begin  // [RULE_16]
      r_next.phase       = r_reg.phase + r_reg.freq;
      r_next.phase_msb_d = r_reg.phase[FREQ_W-1];
      case (r_reg.state)
        FSS_IDLE: begin
          r_next.phase = '0;
          if (trig_rise) begin
            r_next.state     = FSS_RUN;  // [RULE_12]
            r_next.freq      = r_reg.start_freq;  // [RULE_02] [RULE_12]
            r_next.idx       = '0;
            r_next.dwell_cnt = r_reg.dwell[10:0];
            r_next.pre_cnt   = 9'h000;
            r_next.eos       = 1'b0;  // [RULE_23]
          end
        end
        FSS_RUN: begin
          if (r_reg.src_ext) begin
            step_evt = trig_rise;  // [RULE_14]
          end else begin
            if (r_reg.dwell[DWELL_UNIT_BIT]) begin
              if (r_reg.pre_cnt >= mult - 9'h001) begin
                r_next.pre_cnt = 9'h000;
                tick = 1'b1;  // [RULE_10]
              end else begin
                r_next.pre_cnt = r_reg.pre_cnt + 9'h001;
              end
            end else begin
              tick = r_reg.phase[FREQ_W-1] & ~r_reg.phase_msb_d;  // [RULE_08]
            end
            if (tick) begin
              if (r_reg.dwell_cnt <= 11'h001) begin
                r_next.dwell_cnt = r_reg.dwell[10:0];
                step_evt = 1'b1;  // [RULE_13] [RULE_11]
              end else begin
                r_next.dwell_cnt = r_reg.dwell_cnt - 11'h001;
              end
            end
          end
          if (step_evt) begin
            if (r_reg.idx == r_reg.step_count) begin
              r_next.state = FSS_DONE;  // [RULE_11] [RULE_26]
              r_next.eos   = 1'b1;  // [RULE_22]
            end else begin
              r_next.idx      = r_reg.idx + 12'h001;
              r_next.freq     = r_reg.fstep_down ? r_reg.freq - fstep_ext
                                                 : r_reg.freq + fstep_ext;  // [RULE_01]
              r_next.mark_cnt = MARK_PULSE_CYCLES;  // [RULE_22]
            end
          end
        end
        FSS_DONE: begin
          // last frequency runs on; only a reset leaves this state
          r_next.state = FSS_DONE;  // [RULE_26]
        end
        default: begin
          r_next.state = FSS_IDLE;
        end
      endcase
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    if (r_reg.shape_sine) begin
      wave = sine_of(r_reg.phase);  // [RULE_18]
    end else begin
      wave = r_reg.phase[FREQ_W-1] ? ~r_reg.phase[FREQ_W-2:FREQ_W-11]
                                   : r_reg.phase[FREQ_W-2:FREQ_W-11];  // [RULE_18]
    end
    if (standby) begin
      r_next.dac = r_reg.dac;  // [RULE_16]
    end else if (reset_scan || r_reg.state == FSS_IDLE || !r_reg.dac_en) begin
      r_next.dac = DAC_MIDSCALE;  // [RULE_15]
    end else begin
      r_next.dac = wave;
    end
    r_next.square = r_reg.sq_en & ~r_reg.dac[DAC_W-1];  // [RULE_20]
    r_next.marker = r_reg.mark_mode ? r_reg.eos
                                    : (r_reg.mark_cnt != 3'h0);  // [RULE_21] [RULE_23]
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      r_reg            <= '0;
      r_reg.dac_en     <= RST_DAC_EN;
      r_reg.shape_sine <= RST_SHAPE;
      r_reg.state      <= FSS_IDLE;
      r_reg.dac        <= DAC_MIDSCALE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ANALOG_OUT      = r_reg.dac;
  assign SQUARE_WAVE_OUT = r_reg.square;
  assign SCAN_MARKER_OUT = r_reg.marker;
  assign SCAN_MARKER_OE  = r_reg.mark_en;  // [RULE_21] [RULE_23]

endmodule

// ---- bench/fss_host.sv ----
module fss_host (
  output logic sclk,
  output logic fs_n,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // framed serial writer
  // ----------------------------------------
  // link clock idles high and stands still between frames
  initial begin
    sclk = 1'b1;
    fs_n = 1'b1;
    sdi  = 1'b0;
  end
  task automatic send(input logic [15:0] w);
    fs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i]; // msb first, changed while clock high
      #3 sclk = 1'b0; // device captures on this fall, 16 per frame
      #3 sclk = 1'b1;
    end
    fs_n = 1'b1;
    sdi  = ~sdi; // released line has no pull, so show the inverse
    #60;
  endtask
endmodule

// ---- bench/fss_top_props.sv ----
module fss_top_props
  import fss_pkg::*;
(
  input wire logic             MCLK,
  input wire logic             RST_N,
  input wire logic             FRAME_SELECT_N,
  input wire logic             ABORT,
  input wire logic             STANDBY,
  input wire logic [DAC_W-1:0] ANALOG_OUT,
  input wire logic             SQUARE_WAVE_OUT,
  input wire logic             SCAN_MARKER_OUT,
  input wire logic             SCAN_MARKER_OE
);
  // ----------------------------------------
  // cycles since the link was last framed
  // ----------------------------------------
  logic [3:0] quiet_reg;
  logic [3:0] quiet_next;
  always_comb begin
    quiet_next = quiet_reg;
    if (!FRAME_SELECT_N) quiet_next = 4'h0;
    else if (quiet_reg != 4'hF) quiet_next = quiet_reg + 4'h1;
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) quiet_reg <= 4'hF;
    else quiet_reg <= quiet_next;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_reset_values:
    assert property (disable iff (1'b0) !RST_N |-> ANALOG_OUT == DAC_MIDSCALE
      && !SQUARE_WAVE_OUT && !SCAN_MARKER_OUT && !SCAN_MARKER_OE)
      else $error("outputs not at reset values");
  a_sq_inverts:
    assert property (SQUARE_WAVE_OUT |-> !$past(ANALOG_OUT[DAC_W-1]))
      else $error("square high while converter msb was high");
  a_sq_tracks:
    assert property (quiet_reg == 4'hF && $past(SQUARE_WAVE_OUT)
      && !$past(ANALOG_OUT[DAC_W-1]) |-> SQUARE_WAVE_OUT)
      else $error("square dropped while enabled and msb low");
  a_abort_mid:
    assert property ($rose(ABORT) |-> ##[2:6] (ANALOG_OUT == DAC_MIDSCALE) [*4])
      else $error("abort did not bring output to midscale");
  a_standby_hold:
    assert property (STANDBY && $past(STANDBY, 6) |-> $stable(ANALOG_OUT))
      else $error("output moved in standby");
  a_standby_square:
    assert property (STANDBY && $past(STANDBY, 7) |-> $stable(SQUARE_WAVE_OUT))
      else $error("square moved in standby");
  a_marker_pulse_len:
    assert property ($rose(SCAN_MARKER_OUT) |-> SCAN_MARKER_OUT [*4])
      else $error("marker high for under four clocks");
  a_oe_cause:
    assert property (!$stable(SCAN_MARKER_OE) |-> quiet_reg < 4'hC)
      else $error("marker enable changed without a write");
  // hazard: ranges assume no trigger near an abort, as the bench keeps it
  c_marker: cover property ($rose(SCAN_MARKER_OUT));
  c_square: cover property ($rose(SQUARE_WAVE_OUT));
  c_standby: cover property ($fell(STANDBY));
endmodule
bind fss_top fss_top_props u_fss_top_props (.MCLK, .RST_N, .FRAME_SELECT_N, .ABORT,
  .STANDBY, .ANALOG_OUT, .SQUARE_WAVE_OUT, .SCAN_MARKER_OUT, .SCAN_MARKER_OE);

// ---- bench/fss_top_test.sv ----
module fss_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import fss_pkg::*;
  typedef struct { int k; int gap; } fss_exp_t;
  logic       mclk = 1'b0;
  // starts high so the drop below is a real edge for all three async resets
  logic       rst_n = 1'b1;
  logic       trig = 1'b0;
  logic       abrt = 1'b0;
  logic       stby = 1'b0;
  logic       sq, mk, mk_oe, mk_d;
  logic [9:0] ana;
  wire        sclk, fs_n, sdi;
  fss_exp_t   exp_q[$];
  int         errors = 0, num_checks = 0, cyc = 0, last_t = 0, rises = 0;
  int         prev = 512, cand = 0, cur = 0, g, r;
  int         mul[4] = '{1, 5, 100, 500};
  logic [3:0] bad[6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF};
  initial forever #5 mclk = ~mclk;
  fss_host u_fss_host (.sclk(sclk), .fs_n(fs_n), .sdi(sdi));
  fss_top u_fss_top (.MCLK(mclk), .RST_N(rst_n), .SCLK(sclk), .FRAME_SELECT_N(fs_n),
    .SERIAL_DATA_IN(sdi), .SCAN_TRIGGER(trig), .ABORT(abrt), .STANDBY(stby),
    .ANALOG_OUT(ana), .SQUARE_WAVE_OUT(sq), .SCAN_MARKER_OUT(mk), .SCAN_MARKER_OE(mk_oe));
  // ----------------------------------------
  // compare helpers
  // ----------------------------------------
  task automatic cmp_int(int got, int want);
    num_checks++;
    if (got != want) begin
      errors++;
      $display("Error %0t: got %0d want %0d", $time, got, want);
    end
  endtask
  task automatic cmp_bit(logic got, logic want);
    num_checks++;
    if (got !== want) begin
      errors++;
      $display("Error %0t: pin %b want %b", $time, got, want);
    end
  endtask
  // ----------------------------------------
  // watcher: triangle slope gives the tuning word in units of 8192
  // ----------------------------------------
  always @(posedge mclk) begin
    int d;
    cyc++;
    if (mk && !mk_d) rises++;
    mk_d = mk;
    d = int'(ana) - prev;
    if (d < 0) d = -d;
    prev = int'(ana);
    if (d == 0 && cand == 0) cur = 0;
    // a fold of the triangle gives one odd slope, so a new one must repeat
    if (d == cand && d != cur && d != 0) begin
      cur = d;
      if (exp_q.size() == 0) cmp_int(d, 0);
      else begin
        fss_exp_t e;
        e = exp_q.pop_front();
        cmp_int(d, e.k);
        if (e.gap > 0) cmp_int(cyc - last_t, e.gap);
        if (e.gap < 0) cmp_int(int'(cyc - last_t >= -e.gap), 1);
      end
      last_t = cyc;
    end
    cand = d;
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic trg();
    trig = 1'b1;
    tick(4);
    trig = 1'b0;
    tick(4);
  endtask
  function automatic logic [15:0] dw(logic unit, int m, int c);
    return {CMD_DWELL_TOP, unit, 2'(m), 11'(c)}; // unit and multiplier
  endfunction
  task automatic setup(logic [15:0] ctl, int k, int s, logic neg, int n, logic [15:0] d, int gp);
    u_fss_host.send(16'h0D13 | ctl); // converter kept on, scan reset
    u_fss_host.send({CMD_START_LO, 12'h000}); // low half first
    u_fss_host.send({CMD_START_HI, 12'(2 * k)});
    u_fss_host.send({CMD_FSTEP_LO, 12'h000}); // step in two words
    u_fss_host.send({CMD_FSTEP_HI, neg, 11'(2 * s)}); // direction
    u_fss_host.send({CMD_STEP_COUNT, 12'(n)}); // count of two or more
    u_fss_host.send(d); // dwell count of two or more
    for (int i = 0; i <= n; i++)
      exp_q.push_back(fss_exp_t'{neg ? k - i * s : k + i * s, i ? gp : 0});
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    end_of_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    r = $urandom(86);
    // the link side only resets on this edge: its clock idles high
    #1 rst_n = 1'b0;
    tick(12);
    rst_n = 1'b1;
    tick(4);
    foreach (mul[i]) begin
      setup(16'h000C, 1, 1, 1'b0, 2, dw(1'b1, i, 4), 4 * mul[i]);
      foreach (bad[j]) u_fss_host.send({bad[j], 12'($urandom)});
      trg();
      tick(12 * mul[i] + 20);
      cmp_bit(mk, 1'b1);
      cmp_bit(mk_oe, 1'b1);
      trg();
      tick(40);
    end
    g = 30 + $urandom_range(30);
    setup(16'h0024, 9, 2, 1'b1, 3, dw(1'b1, 0, 2), g + 8);
    rises = 0;
    repeat (4) begin
      trg();
      tick(g);
    end
    cmp_int(rises, 3);
    abrt = 1'b1;
    tick(6);
    abrt = 1'b0;
    tick(10);
    exp_q.push_back(fss_exp_t'{9, 0});
    trg();
    tick(20);
    exp_q.push_back(fss_exp_t'{9, 0});
    stby = 1'b1;
    tick(30);
    stby = 1'b0;
    tick(20);
    setup(16'h0000, 8, 8, 1'b0, 2, dw(1'b0, 0, 2), -100);
    trg();
    tick(1200);
    cmp_bit(mk_oe, 1'b0);
    cmp_int(exp_q.size(), 0);
    end_of_test();
  end
endmodule
